// ==== core/sar_conversion_sequencer.sv ====
// Conversion sequencer of a 16-bit successive-approximation converter
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - A falling edge on the trigger starts a conversion and raises status at that edge.
// - Status stays high for the whole conversion and falls only when it is finished.
// - The successive-approximation DAC state is cleared at the trigger falling edge.
// - A rising edge closely after a falling edge replaces the internal clock pulse.
// - In external-clock use one conversion completes after 17 pulses.
// - In external-clock use status rises at the first pulse's falling edge and falls after the 17th.
// - Serial and parallel outputs change on rising bit-clock edges, and parallel data also clears one clock after status rises; serial MSB first NRZ.
// - An asserted short-cycle input ends the conversion early after the current decision.
module sar_conversion_sequencer
	import sar_seq_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// Trigger and analog compare
	input wire logic convert_n_i,
	input wire logic comp_i,
	input wire logic short_cycle_i,
	// Status and results
	output logic busy_o,
	output logic ext_paced_o,
	output logic bit_clk_o,
	output logic serial_o,
	output logic [15:0] data_o,
	output logic [15:0] dac_code_o
);
	bit_step_if st ();

	seq_state_type state;
	seq_state_type next_state;
	logic trig_q;
	logic [7:0] low_cnt;
	logic [7:0] next_low_cnt;
	logic [7:0] div_cnt;
	logic [7:0] next_div_cnt;
	logic ext_mode;
	logic next_ext_mode;
	logic start_seen;
	logic next_start_seen;
	logic [4:0] pulse_cnt;
	logic [4:0] next_pulse_cnt;
	logic fall;
	logic rise;
	logic narrow;
	logic int_tick;
	logic ext_tick;
	logic tick;
	logic finish;
	logic bit_clk;
	logic serial;
	logic [15:0] data;
	logic [15:0] dac_code;

	function automatic logic width_ok(input logic [7:0] cnt);
		width_ok = (cnt >= PULSE_MIN_CYC) && (cnt <= PULSE_MAX_CYC);
	endfunction

	assign fall = trig_q && !convert_n_i;
	assign rise = !trig_q && convert_n_i;
	assign narrow = rise && width_ok(low_cnt);
	// Internal pulses stop once an external clock has taken over
	assign int_tick = (state == CONVERT) && !ext_mode && (div_cnt == INT_PERIOD_CYC - 8'h01);
	assign ext_tick = (state == CONVERT) && ext_mode && narrow && start_seen;
	assign tick = int_tick || ext_tick;
	assign finish = tick && (st.last || short_cycle_i);

	assign st.clear = (state == IDLE) && fall;
	assign st.tick = tick;
	assign st.comp = comp_i;

	always_comb begin
		next_state = state;
		next_low_cnt = low_cnt;
		next_div_cnt = div_cnt;
		next_ext_mode = ext_mode;
		next_start_seen = start_seen;
		next_pulse_cnt = pulse_cnt;
		if (fall) begin
			next_low_cnt = 8'h01;
		end else if (!convert_n_i && low_cnt != 8'hFF) begin
			next_low_cnt = low_cnt + 8'h01;
		end
		case (state)
			IDLE: begin
				if (fall) begin
					next_state = CONVERT;
					next_div_cnt = 8'h00;
					next_ext_mode = 1'b0;
					next_start_seen = 1'b0;
					next_pulse_cnt = 5'h01;
				end
			end
			CONVERT: begin
				next_div_cnt = (div_cnt == INT_PERIOD_CYC - 8'h01) ? 8'h00 : div_cnt + 8'h01;
				if (rise && !start_seen) begin
					// A narrow start pulse means the host is pacing
					next_start_seen = 1'b1;
					next_ext_mode = narrow && !int_tick;
				end
				if (ext_tick) begin
					next_pulse_cnt = pulse_cnt + 5'h01;
				end
				if (finish) begin
					next_state = IDLE;
				end
			end
			default: begin
				next_state = IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state <= IDLE;
			trig_q <= 1'b1;
			low_cnt <= 8'h00;
			div_cnt <= 8'h00;
			ext_mode <= 1'b0;
			start_seen <= 1'b0;
			pulse_cnt <= 5'h00;
		end else begin
			state <= next_state;
			trig_q <= convert_n_i;
			low_cnt <= next_low_cnt;
			div_cnt <= next_div_cnt;
			ext_mode <= next_ext_mode;
			start_seen <= next_start_seen;
			pulse_cnt <= next_pulse_cnt;
		end
	end

	sar_step u_step (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.st(st)
	);

	// bit_clk_o, serial_o and data_o carry the decision being registered in this cycle
	always_comb begin
		bit_clk = tick;
		serial = serial_o;
		data = st.result;
		dac_code = st.trial;
		if (tick) begin
			serial = comp_i;
			// Fresh decision goes out now, so data is final when status falls
			data = comp_i ? st.trial : st.result;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			busy_o <= 1'b0;
			ext_paced_o <= 1'b0;
			bit_clk_o <= 1'b0;
			serial_o <= 1'b0;
			data_o <= RESULT_RST;
			dac_code_o <= RESULT_RST;
		end else begin
			busy_o <= (next_state == CONVERT);
			ext_paced_o <= next_ext_mode;
			bit_clk_o <= bit_clk;
			serial_o <= serial;
			data_o <= data;
			dac_code_o <= dac_code;
		end
	end

	// Helper: decisions since start, for the timing checks
	logic [4:0] dec_cnt;
	always_ff @(posedge clock_i) begin
		if (rst_i || st.clear) begin
			dec_cnt <= 5'h00;
		end else if (tick && dec_cnt != 5'h1F) begin
			dec_cnt <= dec_cnt + 5'h01;
		end
	end

	start_busy_a: assert property (@(posedge clock_i) disable iff (rst_i)
		state == IDLE && fall |=> busy_o)
		else $error("status not raised at trigger falling edge");
	busy_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
		state == CONVERT && !finish |=> busy_o)
		else $error("status dropped before conversion finished");
	busy_drop_a: assert property (@(posedge clock_i) disable iff (rst_i)
		finish |=> !busy_o && data_o == $past(st.result | (comp_i ? 16'h0001 : 16'h0000))
			|| $past(!st.last))
		else $error("status or result wrong at end of conversion");
	full_len_a: assert property (@(posedge clock_i) disable iff (rst_i)
		$fell(busy_o) && !$past(short_cycle_i) |-> dec_cnt == 5'h10)
		else $error("full conversion did not take sixteen decisions");
	ext_count_a: assert property (@(posedge clock_i) disable iff (rst_i)
		$fell(busy_o) && $past(ext_mode) && !$past(short_cycle_i)
			|-> pulse_cnt == PULSES_PER_CONV)
		else $error("external conversion not seventeen pulses long");
	ext_inhibit_a: assert property (@(posedge clock_i) disable iff (rst_i)
		tick && ext_mode |-> $rose(convert_n_i))
		else $error("internal pulse not suppressed in external mode");
	ext_status_a: assert property (@(posedge clock_i) disable iff (rst_i)
		ext_tick && !short_cycle_i && pulse_cnt < PULSES_PER_CONV - 5'h01 |=> busy_o)
		else $error("status fell before the last external pulse");
	short_end_a: assert property (@(posedge clock_i) disable iff (rst_i)
		state == CONVERT && tick && short_cycle_i |=> !busy_o && bit_clk_o)
		else $error("short cycle did not end the conversion");
	int_pace_a: assert property (@(posedge clock_i) disable iff (rst_i)
		state == CONVERT && !ext_mode && div_cnt == 8'h00 |-> ##9 (int_tick || !busy_o
			|| ext_mode))
		else $error("internal clock period not honoured");
	serial_out_a: assert property (@(posedge clock_i) disable iff (rst_i)
		tick |=> bit_clk_o && serial_o == $past(comp_i) && serial_o == st.bit_out)
		else $error("serial bit not presented with its clock");
	hold_result_a: assert property (@(posedge clock_i) disable iff (rst_i)
		state == IDLE && !fall && !$past(busy_o) |=> $stable(data_o))
		else $error("result changed between conversions");

	int_conv_c: cover property (@(posedge clock_i) disable iff (rst_i)
		$fell(busy_o) && !ext_mode && dec_cnt == 5'h10);
	ext_conv_c: cover property (@(posedge clock_i) disable iff (rst_i)
		$fell(busy_o) && pulse_cnt == PULSES_PER_CONV);
	short_conv_c: cover property (@(posedge clock_i) disable iff (rst_i)
		$fell(busy_o) && dec_cnt < 5'h10);
endmodule
`default_nettype wire

// ==== common/sar_seq_pkg.sv ====
// Constants and types shared by the conversion sequencer and its bit-decision stage
package sar_seq_pkg;
	localparam int DATA_W = 16;
	localparam logic [15:0] MSB_MASK = 16'h8000;
	localparam logic [15:0] RESULT_RST = 16'h0000;
	localparam logic [4:0] PULSES_PER_CONV = 5'h11;
	localparam int CLK_NS = 100;
	localparam int INT_PERIOD_NS = 1000;
	localparam int PULSE_MIN_NS = 100;
	localparam int PULSE_MAX_NS = 700;
	localparam logic [7:0] INT_PERIOD_CYC = 8'((INT_PERIOD_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] PULSE_MIN_CYC = 8'((PULSE_MIN_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] PULSE_MAX_CYC = 8'(PULSE_MAX_NS / CLK_NS);
	typedef enum logic {IDLE, CONVERT} seq_state_type;
endpackage

// ==== common/bit_step_if.sv ====
// Carrier between the sequencer and the bit-decision stage
`timescale 1ns/10ps
`default_nettype none
interface bit_step_if;
	logic clear;
	logic tick;
	logic comp;
	logic [15:0] result;
	logic [15:0] trial;
	logic bit_out;
	logic last;
	modport seq (output clear, output tick, output comp,
		input result, input trial, input bit_out, input last);
	modport step (input clear, input tick, input comp,
		output result, output trial, output bit_out, output last);
endinterface
`default_nettype wire

// ==== core/sar_step.sv ====
// Successive-approximation register: one bit decision per tick, MSB first
`timescale 1ns/10ps
`default_nettype none
module sar_step
	import sar_seq_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// Sequencer side
	bit_step_if.step st
);
	logic [15:0] result;
	logic [15:0] mask;
	logic bit_q;
	logic [15:0] next_result;
	logic [15:0] next_mask;
	logic next_bit;

	always_comb begin
		next_result = result;
		next_mask = mask;
		next_bit = bit_q;
		if (st.clear) begin
			// DAC cleared before any decision
			next_result = RESULT_RST;
			next_mask = MSB_MASK;
		end else if (st.tick && mask != RESULT_RST) begin
			next_result = st.comp ? (result | mask) : result;
			next_bit = st.comp;
			next_mask = mask >> 1;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			result <= RESULT_RST;
			mask <= RESULT_RST;
			bit_q <= 1'b0;
		end else begin
			result <= next_result;
			mask <= next_mask;
			bit_q <= next_bit;
		end
	end

	assign st.result = result;
	assign st.trial = result | mask;
	assign st.bit_out = bit_q;
	assign st.last = mask[0];

	mask_walk_a: assert property (@(posedge clock_i) disable iff (rst_i)
		st.tick && !st.clear && mask != RESULT_RST |=> mask == $past(mask) >> 1)
		else $error("decision mask did not advance by one bit");
	clear_dac_a: assert property (@(posedge clock_i) disable iff (rst_i)
		st.clear |=> result == RESULT_RST && mask == MSB_MASK)
		else $error("DAC state not cleared at conversion start");
endmodule
`default_nettype wire

// ==== test/host_sampler.sv ====
// Host sampling controller model: trigger pulses and track/hold flip-flop
`timescale 1ns/10ps
`default_nettype none
module host_sampler (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// Converter status
	input wire logic busy_i,
	// Trigger and track/hold
	output logic convert_n_o,
	output logic hold_o
);
	logic conv_prev;
	logic busy_prev;
	initial convert_n_o = 1'b1;
	// Narrow low pulses keep hold droop small
	task pulse(input int low);
		@(negedge clock_i);
		convert_n_o = 1'b0;
		repeat (low) @(negedge clock_i);
		convert_n_o = 1'b1;
	endtask
	always @(posedge clock_i) begin
		if (rst_i) begin
			hold_o <= 1'b0;
		end else if (convert_n_o && !conv_prev) begin
			hold_o <= 1'b1;
		end else if (!busy_i && busy_prev) begin
			hold_o <= 1'b0;
		end
		conv_prev <= convert_n_o;
		busy_prev <= busy_i;
	end
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench of the conversion sequencer
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic convert_n;
	logic comp_i;
	logic short_cycle_i;
	logic busy_o;
	logic ext_paced_o;
	logic bit_clk_o;
	logic serial_o;
	logic [15:0] data_o;
	logic [15:0] dac_code_o;
	logic hold_o;
	logic [15:0] vin = 16'h0000;
	logic [15:0] ser = 16'h0000;
	int nbits = 0;
	int sc = 0;
	int errors = 0;
	int total_checks = 0;
	always #50 clock_i = ~clock_i;
	host_sampler host (.clock_i(clock_i), .rst_i(rst_i), .busy_i(busy_o),
		.convert_n_o(convert_n), .hold_o(hold_o));
	sar_conversion_sequencer DUT (.clock_i(clock_i), .rst_i(rst_i), .convert_n_i(convert_n),
		.comp_i(comp_i), .short_cycle_i(short_cycle_i), .busy_o(busy_o),
		.ext_paced_o(ext_paced_o), .bit_clk_o(bit_clk_o), .serial_o(serial_o),
		.data_o(data_o), .dac_code_o(dac_code_o));
	// Ideal comparator against the held input
	always @(negedge clock_i) begin
		comp_i <= (dac_code_o <= vin);
		short_cycle_i <= (sc != 0) && (nbits >= sc - 1);
	end
	always @(posedge clock_i) begin
		if (bit_clk_o === 1'b1) begin
			ser <= {ser[14:0], serial_o};
			nbits <= nbits + 1;
		end
	end
	task check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wait_idle(input int lim);
		int i;
		i = 0;
		while (busy_o !== 1'b0 && i < lim) begin
			@(negedge clock_i);
			i++;
		end
		// Let the last bit clock reach the serial sampler
		@(negedge clock_i);
		check({15'h0000, busy_o}, 16'h0000);
	endtask
	task prep(input logic [15:0] v, input int s);
		vin = v;
		sc = s;
		ser = 16'h0000;
		nbits = 0;
	endtask
	task ext_paced;
		prep(16'h3C5A, 0);
		host.pulse(3);
		repeat (2) @(negedge clock_i);
		check({15'h0000, hold_o}, 16'h0001);
		check({15'h0000, ext_paced_o}, 16'h0001);
		check({15'h0000, busy_o}, 16'h0001);
		repeat (15) begin
			repeat (8) @(negedge clock_i);
			host.pulse(3);
		end
		repeat (8) @(negedge clock_i);
		check({15'h0000, busy_o}, 16'h0001);
		host.pulse(3);
		wait_idle(4);
		check(data_o, vin);
		check(ser, vin);
		check(16'(nbits), 16'h0010);
		repeat (2) @(negedge clock_i);
		check({15'h0000, hold_o}, 16'h0000);
	endtask
	task int_paced;
		prep(16'hA5C3, 0);
		fork host.pulse(10); join_none
		repeat (3) @(negedge clock_i);
		check({15'h0000, busy_o}, 16'h0001);
		check(dac_code_o, 16'h8000);
		repeat (28) @(negedge clock_i);
		// Wide low pulse mid-run must not restart
		fork host.pulse(10); join_none
		repeat (118) @(negedge clock_i);
		check({15'h0000, busy_o}, 16'h0001);
		wait_idle(30);
		check(data_o, vin);
		check(ser, vin);
		check(16'(nbits), 16'h0010);
	endtask
	task short_cyc;
		prep(16'h9E37, 10);
		fork host.pulse(10); join_none
		repeat (3) @(negedge clock_i);
		wait_idle(120);
		check(data_o, 16'h9E00);
		check(ser, 16'h0278);
		check(16'(nbits), 16'h000A);
		sc = 0;
	endtask
	task wrap_up;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(negedge clock_i);
		rst_i = 1'b0;
		repeat (2) @(negedge clock_i);
		ext_paced;
		int_paced;
		short_cyc;
		wrap_up;
	end
	// Whole run is under 800 cycles
	initial begin
		#500000;
		errors++;
		wrap_up;
	end
endmodule
`default_nettype wire
